// ===== hw/pll_loader_pkg.sv
// Constants shared by the serial latch loader.
// Assumes a 50 MHz system clock and a host-driven shift clock.
package pll_loader_pkg;
    localparam int WORD_BITS = 24;
    localparam int ADDR_BITS = 2;
    localparam int REF_DIV_BITS = 14;
    localparam int FB_DIV_BITS = 13;
    localparam int FUNC_BITS = 22;
    // Destination select codes in the two low bits of a word
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    // Field positions inside a word
    localparam int REF_DIV_LSB = 2;
    localparam int FB_DIV_LSB = 8;
    localparam int MUX_SEL_LSB = 4;
    localparam int MUX_SEL_BITS = 3;
    localparam int COUNT_RESET_BIT = 2;
    localparam int PDOWN1_BIT = 3;
    // Status output selections
    localparam logic [2:0] MUX_LOW = 3'h0;
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_REF_DIV = 3'h4;
    localparam logic [2:0] MUX_HIGH = 3'h7;
    // Values after reset
    localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h000000;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [3:0] SEEN_RESET = 4'h0;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_COPY = 2'b01
    } load_state_t;
endpackage : pll_loader_pkg

// ===== hw/level_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input is a level held longer than two destination clocks.
module level_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1_q <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule : level_sync

// ===== hw/pll_serial_latch_loader.sv
// Three-wire serial latch loader with power-up sequencing and status mux.
// Assumes the host drives shiftClk, serial_input_line and latch_strobe;
// the shift logic runs on shiftClk, the latches on clk (50 MHz).
//
// Behaviour
// - Shift data in on each shift clock rise
// - Strobe rise copies 24 bits into latch
// - Output inactive until reference, feedback, init written
// - Divider values of one are accepted
// - Status output can show lock detect
// - Power-enable input controls power-down
// - Low two bits select destination latch
// - Shifting and latching work while powered down
module pll_serial_latch_loader #(
    parameter int WORD_W = pll_loader_pkg::WORD_BITS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic shiftClk,
    input wire logic serial_input_line,
    input wire logic latch_strobe,
    input wire logic chipEnable,
    input wire logic lockDetect,
    input wire logic refDivTick,
    output logic muxed_status_output,
    output logic outputActive,
    output logic poweredDown,
    output logic counterReset,
    output logic [pll_loader_pkg::REF_DIV_BITS-1:0] refDivide,
    output logic [pll_loader_pkg::FB_DIV_BITS-1:0] fbDivide,
    output logic [pll_loader_pkg::FUNC_BITS-1:0] functionWord
);
    // Link domain: shift register on the host clock. It has no reset of its
    // own since the host clock may stand still; the word is only trusted
    // once the strobe rises, after which shiftClk is idle.
    logic [WORD_W-1:0] shiftReg_q;
    always_ff @(posedge shiftClk) begin
        shiftReg_q <= {shiftReg_q[WORD_W-2:0], serial_input_line};
    end

    // Every pin-side level below passes two flops before any logic reads it.
    // The strobe crosses as a level; the word is stable while it is high
    // because the host does not shift with the strobe high.
    logic strobeSync;
    logic ceSync;
    logic lockSync;
    logic tickSync;

    level_sync u_strobe_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(latch_strobe),
        .syncOut(strobeSync)
    );

    // Power enable from the host port
    level_sync u_ce_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(chipEnable),
        .syncOut(ceSync)
    );

    // Lock indication from the loop
    level_sync u_lock_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(lockDetect),
        .syncOut(lockSync)
    );

    // Reference divider output, used only as a status selection
    level_sync u_tick_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(refDivTick),
        .syncOut(tickSync)
    );

    // Reset high for a strobe that idles high; strobeSync still resets low,
    // so a rise is reported two cycles after reset and copies an unshifted word.
    logic strobe_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= strobeSync;
        end
    end

    logic strobeRise;
    assign strobeRise = strobeSync & ~strobe_q;

    // Sequencer: one copy cycle per strobe rise. The rise is seen two flops
    // late, so the shift register has long settled when it is read.
    pll_loader_pkg::load_state_t state_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= pll_loader_pkg::LD_IDLE;
        end else begin
            case (state_q)
                // Waiting for the host to commit a word
                pll_loader_pkg::LD_IDLE: begin
                    if (strobeRise) begin
                        state_q <= pll_loader_pkg::LD_COPY;
                    end
                end
                // Snapshot held; destination latch loads now
                pll_loader_pkg::LD_COPY: begin
                    state_q <= pll_loader_pkg::LD_IDLE;
                end
                default: begin
                    state_q <= pll_loader_pkg::LD_IDLE;
                end
            endcase
        end
    end

    // Word snapshot in the system domain; the high strobe is the handshake
    // that keeps shiftReg_q still while it is read. A host that shifts with
    // the strobe high can corrupt this copy.
    logic [WORD_W-1:0] word_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            word_q <= pll_loader_pkg::WORD_RESET;
        end else if ((state_q == pll_loader_pkg::LD_IDLE) && strobeRise) begin
            word_q <= shiftReg_q;
        end
    end

    // Destination select sits in the low two bits of the snapshot
    logic loadNow;
    logic [1:0] sel;
    assign loadNow = (state_q == pll_loader_pkg::LD_COPY);
    assign sel = word_q[pll_loader_pkg::ADDR_BITS-1:0];

    // One load enable per destination latch; at most one is high
    logic loadRef;
    logic loadFb;
    logic loadFunc;
    logic loadInit;

    always_comb begin
        loadRef = 1'b0;
        loadFb = 1'b0;
        loadFunc = 1'b0;
        loadInit = 1'b0;
        if (loadNow) begin
            case (sel)
                pll_loader_pkg::SEL_REF: begin
                    loadRef = 1'b1;
                end
                pll_loader_pkg::SEL_FB: begin
                    loadFb = 1'b1;
                end
                pll_loader_pkg::SEL_FUNC: begin
                    loadFunc = 1'b1;
                end
                pll_loader_pkg::SEL_INIT: begin
                    loadInit = 1'b1;
                end
                // Unreachable: the select has only four codes
                default: begin
                    loadRef = 1'b0;
                end
            endcase
        end
    end

    // Divider latches store any value, one included; zero is kept as
    // written, so the host must not program a zero divide.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            refDivide <= '0;
        end else if (loadRef) begin
            refDivide <= word_q[pll_loader_pkg::REF_DIV_LSB +:
                pll_loader_pkg::REF_DIV_BITS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fbDivide <= '0;
        end else if (loadFb) begin
            fbDivide <= word_q[pll_loader_pkg::FB_DIV_LSB +:
                pll_loader_pkg::FB_DIV_BITS];
        end
    end

    // Function and initialisation words share one latch; only the
    // initialisation write adds the counter reset pulse.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            functionWord <= '0;
        end else if (loadFunc || loadInit) begin
            functionWord <= word_q[WORD_W-1:pll_loader_pkg::ADDR_BITS];
        end
    end

    // Power-up order: one flag per destination written since reset.
    // A function write alone does not count toward an active output.
    logic [3:0] seen_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seen_q <= pll_loader_pkg::SEEN_RESET;
        end else begin
            seen_q <= seen_q | {loadInit, loadFunc, loadFb, loadRef};
        end
    end

    // Order of the three writes does not matter, only that all were made
    logic allWritten;
    assign allWritten = seen_q[pll_loader_pkg::SEL_REF] & seen_q[pll_loader_pkg::SEL_FB]
        & seen_q[pll_loader_pkg::SEL_INIT];

    // Initialisation write pulses a counter reset for one cycle
    logic initPulse_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            initPulse_q <= 1'b0;
        end else begin
            initPulse_q <= loadInit;
        end
    end

    // Power-down follows the enable pin; latches keep their contents, so
    // the host need not reprogram after waking the device.
    logic pdNext;
    logic countHold;
    assign pdNext = ~ceSync;
    assign countHold = functionWord[pll_loader_pkg::COUNT_RESET_BIT - pll_loader_pkg::ADDR_BITS];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            poweredDown <= 1'b1;
        end else begin
            poweredDown <= pdNext;
        end
    end

    // Output stays inactive until the power-up writes are complete
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            outputActive <= 1'b0;
        end else begin
            outputActive <= allWritten & ~pdNext;
        end
    end

    // Counters are held while powered down, on the init pulse or by the bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            counterReset <= 1'b0;
        end else begin
            counterReset <= initPulse_q | pdNext | countHold;
        end
    end

    // Status selection; lock is masked until the power-up order is done so
    // the host never reads lock from an unprogrammed loop.
    logic [2:0] muxSel;
    logic muxNext;
    assign muxSel = functionWord[pll_loader_pkg::MUX_SEL_LSB - pll_loader_pkg::ADDR_BITS +:
        pll_loader_pkg::MUX_SEL_BITS];
    always_comb begin
        muxNext = 1'b0;
        case (muxSel)
            pll_loader_pkg::MUX_LOCK: begin
                muxNext = lockSync & allWritten;
            end
            pll_loader_pkg::MUX_REF_DIV: begin
                muxNext = tickSync;
            end
            pll_loader_pkg::MUX_HIGH: begin
                muxNext = 1'b1;
            end
            default: begin
                muxNext = 1'b0;
            end
        endcase
    end

    // Registered so the pin never shows a decode glitch while the
    // selection changes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            muxed_status_output <= 1'b0;
        end else begin
            muxed_status_output <= muxNext;
        end
    end
endmodule : pll_serial_latch_loader

// ===== bench/loader_assertions.sv
// Port checker for the serial latch loader.
// Assumes it is bound into the loader; all checks run on clk.
module loader_assertions #(parameter int WORD_W = pll_loader_pkg::WORD_BITS) (
    input wire logic clk, rst_b, shiftClk, serial_input_line, latch_strobe, chipEnable,
    input wire logic lockDetect, refDivTick, muxed_status_output, outputActive, poweredDown,
    input wire logic counterReset,
    input wire logic [pll_loader_pkg::REF_DIV_BITS-1:0] refDivide,
    input wire logic [pll_loader_pkg::FB_DIV_BITS-1:0] fbDivide,
    input wire logic [pll_loader_pkg::FUNC_BITS-1:0] functionWord
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_PD_ON: assert property (!chipEnable [*4] |-> poweredDown)
        else $error("power-down late");
    AST_PD_OFF: assert property (chipEnable [*4] |-> !poweredDown)
        else $error("power-down stuck");
    AST_PD_QUIET: assert property (!chipEnable [*5] |-> !outputActive)
        else $error("active while down");
    AST_PD_CRST: assert property (poweredDown [*2] |-> counterReset)
        else $error("counters run while down");
    AST_REF_CAUSE: assert property ($changed(refDivide) |-> $past(latch_strobe, 2))
        else $error("ref latch without strobe");
    AST_FB_CAUSE: assert property ($changed(fbDivide) |-> $past(latch_strobe, 2))
        else $error("fb latch without strobe");
    AST_ONE_LATCH: assert property ($changed(functionWord) |-> $stable(refDivide)
        && $stable(fbDivide)) else $error("two latches hit");
    AST_MUX_HIGH: assert property ((functionWord[4:2] == pll_loader_pkg::MUX_HIGH) [*2]
        |-> muxed_status_output) else $error("mux high");
    AST_MUX_LOW: assert property ((functionWord[4:2] == pll_loader_pkg::MUX_LOW) [*2]
        |-> !muxed_status_output) else $error("mux low");
    AST_MUX_LOCK: assert property ((functionWord[4:2] == pll_loader_pkg::MUX_LOCK
        && outputActive && lockDetect) [*4] |-> muxed_status_output)
        else $error("lock not shown");
    cover property ($rose(outputActive));
    cover property ($changed(fbDivide));
    cover property ($rose(poweredDown));
endmodule : loader_assertions

bind pll_serial_latch_loader loader_assertions #(.WORD_W(WORD_W)) chk (.*);

// ===== bench/host_model.sv
// Behavioural host that writes words over the three-wire link.
// Assumes a 160 ns shift clock, running only within frames.
module host_model (
    output logic shiftClk,
    output logic serial_input_line,
    output logic latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shiftClk = 1'b0;
        serial_input_line = 1'b0;
        latch_strobe = 1'b1;
    end
    task automatic send_word(input logic [23:0] w);
        // Odd offset keeps link edges apart from the system clock edges
        #7;
        latch_strobe = 1'b0;
        #200;
        for (int i = 23; i >= 0; i--) begin
            serial_input_line = w[i];
            #80 shiftClk = 1'b1;
            #80 shiftClk = 1'b0;
        end
        // Line no longer valid: show the opposite level
        serial_input_line = ~w[0];
        #80 latch_strobe = 1'b1;
        #200;
    endtask : send_word
endmodule : host_model

// ===== bench/tb_top.sv
// Self-checking bench for the serial latch loader.
// Assumes host_model drives the link and the checker is bound.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, chipEnable = 1'b1, lockDetect = 1'b0, refDivTick = 1'b0;
    logic shiftClk, serial_input_line, latch_strobe, muxed, outputActive, poweredDown, crst;
    logic [pll_loader_pkg::REF_DIV_BITS-1:0] refDivide;
    logic [pll_loader_pkg::FB_DIV_BITS-1:0] fbDivide;
    logic [pll_loader_pkg::FUNC_BITS-1:0] functionWord;
    logic [2:0] codes[4] = '{pll_loader_pkg::MUX_LOW, pll_loader_pkg::MUX_HIGH,
        pll_loader_pkg::MUX_LOCK, pll_loader_pkg::MUX_REF_DIV};
    logic [23:0] expQ[$];
    logic [15:0] rnd = 16'hB462;
    int error_cnt = 0, num_checks = 0;
    initial forever #10 clk = ~clk;
    host_model host (.shiftClk(shiftClk), .serial_input_line(serial_input_line),
        .latch_strobe(latch_strobe));
    pll_serial_latch_loader DUT (.clk(clk), .rst_b(rst_b), .shiftClk(shiftClk),
        .serial_input_line(serial_input_line), .latch_strobe(latch_strobe),
        .chipEnable(chipEnable), .lockDetect(lockDetect), .refDivTick(refDivTick),
        .muxed_status_output(muxed), .outputActive(outputActive), .poweredDown(poweredDown),
        .counterReset(crst), .refDivide(refDivide), .fbDivide(fbDivide),
        .functionWord(functionWord));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    task automatic cmp_word(input logic [21:0] exp, input logic [21:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t latch %h, expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t status %b, expected %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic write(input logic [1:0] sel, input logic [21:0] body);
        expQ.push_back({body, sel});
        host.send_word({body, sel});
        repeat (6) @(negedge clk);
    endtask : write
    task automatic final_report;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    always @(posedge clk) begin : watch
        logic [23:0] w;
        if (rst_b && ($changed(refDivide) || $changed(fbDivide) || $changed(functionWord))) begin
            w = (expQ.size() > 0) ? expQ.pop_front() : 24'hFFFFFF;
            case (w[1:0])
                pll_loader_pkg::SEL_REF: cmp_word(22'(w[15:2]), 22'(refDivide));
                pll_loader_pkg::SEL_FB: cmp_word(22'(w[20:8]), 22'(fbDivide));
                default: cmp_word(w[23:2], functionWord);
            endcase
        end
    end
    initial begin
        #500us;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        write(pll_loader_pkg::SEL_REF, 22'h000001);
        write(pll_loader_pkg::SEL_FB, 22'h000040);
        cmp_bit(1'b0, outputActive);
        write(pll_loader_pkg::SEL_INIT, {17'h00001, pll_loader_pkg::MUX_LOCK, 2'b00});
        cmp_bit(1'b1, outputActive);
        lockDetect = 1'b1;
        repeat (6) @(negedge clk);
        cmp_bit(1'b1, muxed);
        $display("power-up sequence done");
        chipEnable = 1'b0;
        write(pll_loader_pkg::SEL_REF, 22'h002AAA);
        cmp_bit(1'b1, poweredDown);
        cmp_bit(1'b0, outputActive);
        cmp_bit(1'b1, crst);
        chipEnable = 1'b1;
        repeat (6) @(negedge clk);
        cmp_bit(1'b1, outputActive);
        cmp_bit(1'b0, crst);
        $display("power-down done");
        lockDetect = 1'b0;
        refDivTick = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            write(pll_loader_pkg::SEL_FUNC, {1'b0, rnd, codes[i], 2'b00});
            cmp_bit(i[0], muxed);
        end
        $display("status codes done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            write(rnd[1:0], {rnd[5:0], rnd[15:2], 2'b00});
        end
        $display("random words done");
        cmp_bit(1'b0, expQ.size() != 0);
        final_report();
    end
endmodule : tb_top
